// ==== adp_pkg.sv ====
// package for the ancillary packet detector and payload identifier extractor
// assumes a word-aligned 10-bit smpte luma/chroma stream on the pixel clock
// Functional notes
// - flag ancillary packets in any blanking region
// - flags change synchronously with pixel clock
// - hd: each flag follows its own stream
// - sd 20-bit: flags driven independently per stream
// - sd 10-bit: both flags raised together
// - flag spans preamble first word to checksum
// - five match slots, did high sdid low
// - flag only on a did/sdid slot match or with all slots zero
// - zero did or sdid is a wildcard
// - all slots zero flags everything, reset default
// - some slots programmed: only matches flagged
// - edh packets always detected internally
// - capture four payload id words to registers
// - update payload id only on good checksum
// - clear payload id on reset, unlock, bypass
// - clear payload id after two frames missing
// - active only in smpte processing mode
package adp_pkg;
    // register offsets on the host register port
    localparam logic [7:0]  ADDR_SLOT_1     = 8'h05;
    localparam logic [7:0]  ADDR_SLOT_5     = 8'h09;
    localparam logic [7:0]  ADDR_PID_LOW    = 8'h0c;
    localparam logic [7:0]  ADDR_PID_HIGH   = 8'h0d;
    localparam int          NUM_SLOTS       = 5;
    localparam logic [15:0] SLOT_RESET      = 16'h0000;
    localparam logic [15:0] PID_RESET       = 16'h0000;
    // slot field layout
    localparam int          SLOT_DID_LSB    = 8;
    localparam int          SLOT_SDID_LSB   = 0;
    // ancillary data flag words
    localparam logic [9:0]  ADF0            = 10'h000;
    localparam logic [9:0]  ADF1            = 10'h3ff;
    // word positions inside a packet, counted from the first preamble word
    localparam logic [8:0]  POS_DID         = 9'h003;
    localparam logic [8:0]  POS_UDW         = 9'h006;
    // payload identifier and edh packet identity
    localparam logic [7:0]  PID_DID         = 8'h41;
    localparam logic [7:0]  PID_SDID        = 8'h01;
    localparam logic [7:0]  PID_DC          = 8'h04;
    localparam logic [7:0]  EDH_DID         = 8'hf4;
    // frame boundaries tolerated without a payload id packet
    localparam logic [1:0]  PID_TIMEOUT_FRM = 2'h2;
    // parser delay line depth; the output register adds one more cycle of delay
    localparam int          PIPE_DEPTH      = 6;
endpackage : adp_pkg

// ==== adp_anc_parser.sv ====
// one-stream ancillary packet parser with a short delay line
// assumes word-aligned 10-bit data on the same clock, no synchroniser needed
`timescale 1ns/1ps
module adp_anc_parser
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // stream in
    input  wire logic       i_enable,
    input  wire logic [9:0] i_data,
    // delayed stream and live packet view
    output logic      [9:0] o_data,
    output logic            o_in_packet,
    output logic      [7:0] o_did,
    output logic      [7:0] o_sdid,
    // end-of-packet report
    output logic            o_done,
    output logic            o_csum_ok,
    output logic     [31:0] o_udw
);
    // delay line, index 0 newest
    logic [9:0]  sr_reg [adp_pkg::PIPE_DEPTH];
    logic        act_reg;          // inside a packet
    logic [8:0]  pos_reg;          // position of the oldest word in the packet
    logic [7:0]  len_reg;          // data count of the packet
    logic [7:0]  did_reg;
    logic [7:0]  sdid_reg;
    logic [8:0]  sum_reg;          // running checksum
    logic        done_reg;
    logic        ok_reg;
    logic [31:0] udw_reg;

    // header seen with its first preamble word at the output tap
    wire         hdr_hit   = i_enable && !act_reg && sr_reg[5] == adp_pkg::ADF0
                             && sr_reg[4] == adp_pkg::ADF1 && sr_reg[3] == adp_pkg::ADF1;
    wire  [8:0]  csum_pos  = adp_pkg::POS_UDW + {1'b0, len_reg};
    wire         at_csum   = act_reg && pos_reg == csum_pos;
    wire         in_sum    = act_reg && pos_reg >= adp_pkg::POS_DID && pos_reg < csum_pos;
    wire  [8:0]  udw_idx   = pos_reg - adp_pkg::POS_UDW;
    wire         at_udw    = act_reg && pos_reg >= adp_pkg::POS_UDW && udw_idx < 9'h004
                             && pos_reg < csum_pos;
    wire  [8:0]  sum_next  = sum_reg + sr_reg[5][8:0];
    // low eight bits only, parity bits ignored
    wire  [7:0]  did_live  = hdr_hit ? sr_reg[2][7:0] : did_reg;
    wire  [7:0]  sdid_live = hdr_hit ? sr_reg[1][7:0] : sdid_reg;

    // live outputs: flag spans first preamble word through checksum
    assign o_data      = sr_reg[5];
    assign o_in_packet = hdr_hit || act_reg;
    assign o_did       = did_live;
    assign o_sdid      = sdid_live;
    assign o_done      = done_reg;
    assign o_csum_ok   = ok_reg;
    assign o_udw       = udw_reg;

    // delay line shift
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int i = 0; i < adp_pkg::PIPE_DEPTH; i++)
                sr_reg[i] <= 10'h000;
        end
        else
        begin
            sr_reg[0] <= i_data;
            for (int i = 1; i < adp_pkg::PIPE_DEPTH; i++)
                sr_reg[i] <= sr_reg[i-1];
        end
    end

    // packet walk and checksum
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            act_reg  <= 1'b0;
            pos_reg  <= 9'h000;
            len_reg  <= 8'h00;
            did_reg  <= 8'h00;
            sdid_reg <= 8'h00;
            sum_reg  <= 9'h000;
            done_reg <= 1'b0;
            ok_reg   <= 1'b0;
            udw_reg  <= 32'h0000_0000;
        end
        else
        begin
            done_reg <= at_csum;
            if (!i_enable)
                act_reg <= 1'b0;                     // mode left: abandon packet
            else if (hdr_hit)
            begin
                act_reg  <= 1'b1;
                pos_reg  <= 9'h001;
                len_reg  <= sr_reg[0][7:0];          // data count word
                did_reg  <= did_live;
                sdid_reg <= sdid_live;
                sum_reg  <= 9'h000;
            end
            else if (act_reg)
            begin
                pos_reg <= pos_reg + 9'h001;
                if (in_sum)
                    sum_reg <= sum_next;
                if (at_udw)
                    udw_reg[udw_idx[1:0]*8 +: 8] <= sr_reg[5][7:0];
                if (at_csum)
                begin
                    act_reg <= 1'b0;
                    ok_reg  <= sr_reg[5] == {~sum_reg[8], sum_reg};
                end
            end
        end
    end
endmodule : adp_anc_parser

// ==== adp_anc_detect.sv ====
// ancillary flag generation, match filtering and payload id extraction
// assumes pins are asynchronous (synchronised here) and frame strobe is local
`timescale 1ns/1ps
module adp_anc_detect
(
    // clock and reset
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST,
    // video stream from the word aligner
    input  wire logic  [9:0] I_LUMA_DATA,
    input  wire logic  [9:0] I_CHROMA_DATA,
    input  wire logic        I_FRAME_START,
    // mode pins
    input  wire logic        I_RATE_SELECT,
    input  wire logic        I_MUX_10BIT,
    input  wire logic        I_LOCK_INDICATOR,
    input  wire logic        I_PROCESSING_ENABLE,
    input  wire logic        I_SMPTE_MODE,
    // host register port
    input  wire logic  [7:0] I_HOST_ADDR,
    input  wire logic        I_HOST_WR,
    input  wire logic        I_HOST_RD,
    input  wire logic [15:0] I_HOST_WDATA,
    output logic      [15:0] O_HOST_RDATA,
    // delayed video and flags
    output logic       [9:0] O_LUMA_DATA,
    output logic       [9:0] O_CHROMA_DATA,
    output logic             O_LUMA_ANC_FLAG,
    output logic             O_CHROMA_ANC_FLAG,
    output logic             O_EDH_DETECT
);
    // slot match: zero fields are wildcards, an all-zero slot never matches
    function automatic logic slot_match(input logic [15:0] slot, input logic [7:0] did,
                                        input logic [7:0] sdid);
        logic [7:0] s_did;
        logic [7:0] s_sdid;
        s_did  = slot[adp_pkg::SLOT_DID_LSB +: 8];
        s_sdid = slot[adp_pkg::SLOT_SDID_LSB +: 8];
        return (slot != 16'h0000)
            && (s_did == 8'h00 || s_did == did)
            && (s_sdid == 8'h00 || s_sdid == sdid);
    endfunction : slot_match

    // match against all slots, or pass everything when all are zero
    function automatic logic any_match(input logic [15:0] s [adp_pkg::NUM_SLOTS],
                                       input logic [7:0] did, input logic [7:0] sdid);
        logic hit;
        logic all_zero;
        hit      = 1'b0;
        all_zero = 1'b1;
        for (int i = 0; i < adp_pkg::NUM_SLOTS; i++)
        begin
            hit      = hit | slot_match(s[i], did, sdid);
            all_zero = all_zero & (s[i] == 16'h0000);
        end
        return hit | all_zero;
    endfunction : any_match

    // pin synchronisers: rate, mux, lock, enable, smpte
    logic [4:0]  sync1_reg;        // first stage, read only by sync2_reg
    logic [4:0]  sync2_reg;
    // match slots, did in high byte, sdid in low byte
    logic [15:0] slot_reg [adp_pkg::NUM_SLOTS];
    logic [15:0] pid_low_reg;      // payload id bytes 1 and 2
    logic [15:0] pid_high_reg;     // payload id bytes 3 and 4
    logic [1:0]  tmo_cnt_reg;      // frame boundaries since last good packet or timeout
    logic [15:0] rdata_reg;
    logic        luma_flag_reg;
    logic        chroma_flag_reg;
    logic        edh_reg;
    logic [9:0]  luma_out_reg;
    logic [9:0]  chroma_out_reg;

    // parser connections
    logic [9:0]  l_data;
    logic [9:0]  c_data;
    logic        l_live;
    logic        c_live;
    logic [7:0]  l_did;
    logic [7:0]  l_sdid;
    logic [7:0]  c_did;
    logic [7:0]  c_sdid;
    logic        l_done;
    logic        l_ok;
    logic [31:0] l_udw;
    logic        c_done;
    logic        c_ok;
    logic [31:0] c_udw;

    // decoded mode
    wire         rate_q   = sync2_reg[0];
    wire         mux_q    = sync2_reg[1];
    wire         lock_q   = sync2_reg[2];
    wire         proc_q   = sync2_reg[3];
    wire         smpte_q  = sync2_reg[4];
    wire         proc_on  = proc_q && smpte_q;
    wire         sd_mux   = rate_q && mux_q;             // single muxed stream
    wire         l_match  = any_match(slot_reg, l_did, l_sdid);
    wire         c_match  = any_match(slot_reg, c_did, c_sdid);
    wire         l_flag   = proc_on && l_live && l_match;
    wire         c_flag   = proc_on && c_live && c_match && !sd_mux;
    // both flags together in muxed sd, otherwise independent
    wire         luma_nx  = l_flag;
    wire         chr_nx   = sd_mux ? l_flag : c_flag;
    // edh packets seen regardless of the slots
    wire         edh_nx   = proc_on && ((l_live && l_did == adp_pkg::EDH_DID)
                            || (c_live && c_did == adp_pkg::EDH_DID && !sd_mux));
    // payload id accepted only with the right header and a good checksum
    wire         pid_load = proc_on && l_done && l_ok && l_did == adp_pkg::PID_DID
                            && l_sdid == adp_pkg::PID_SDID;
    wire         tmo_hit  = I_FRAME_START && tmo_cnt_reg == adp_pkg::PID_TIMEOUT_FRM;
    wire         pid_clr  = !lock_q || !proc_q || tmo_hit;
    wire         slot_wr  = I_HOST_WR && I_HOST_ADDR >= adp_pkg::ADDR_SLOT_1
                            && I_HOST_ADDR <= adp_pkg::ADDR_SLOT_5;
    wire  [7:0]  slot_idx = I_HOST_ADDR - adp_pkg::ADDR_SLOT_1;
    wire  [15:0] rd_mux   = (I_HOST_ADDR == adp_pkg::ADDR_PID_LOW)  ? pid_low_reg  :
                            (I_HOST_ADDR == adp_pkg::ADDR_PID_HIGH) ? pid_high_reg :
                            slot_wr || (I_HOST_ADDR >= adp_pkg::ADDR_SLOT_1
                            && I_HOST_ADDR <= adp_pkg::ADDR_SLOT_5)
                            ? slot_reg[slot_idx[2:0]] : 16'h0000;

    // luma stream parser, carries the payload id packet
    adp_anc_parser u_luma
    (
        .i_clk       (I_CORE_CLK),
        .i_rst       (I_RST),
        .i_enable    (proc_on),
        .i_data      (I_LUMA_DATA),
        .o_data      (l_data),
        .o_in_packet (l_live),
        .o_did       (l_did),
        .o_sdid      (l_sdid),
        .o_done      (l_done),
        .o_csum_ok   (l_ok),
        .o_udw       (l_udw)
    );

    // chroma stream parser
    adp_anc_parser u_chroma
    (
        .i_clk       (I_CORE_CLK),
        .i_rst       (I_RST),
        .i_enable    (proc_on),
        .i_data      (I_CHROMA_DATA),
        .o_data      (c_data),
        .o_in_packet (c_live),
        .o_did       (c_did),
        .o_sdid      (c_sdid),
        .o_done      (c_done),
        .o_csum_ok   (c_ok),
        .o_udw       (c_udw)
    );

    // two-stage pin synchroniser
    always_ff @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
        end
        else
        begin
            sync1_reg <= {I_SMPTE_MODE, I_PROCESSING_ENABLE, I_LOCK_INDICATOR,
                          I_MUX_10BIT, I_RATE_SELECT};
            sync2_reg <= sync1_reg;
        end
    end

    // host writes to the match slots
    always_ff @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            for (int i = 0; i < adp_pkg::NUM_SLOTS; i++)
                slot_reg[i] <= adp_pkg::SLOT_RESET;
        end
        else if (slot_wr)
            slot_reg[slot_idx[2:0]] <= I_HOST_WDATA;
    end

    // host read data, one cycle after the read strobe
    always_ff @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
            rdata_reg <= 16'h0000;
        else if (I_HOST_RD)
            rdata_reg <= rd_mux;
    end

    // payload id capture; a good packet wins over a clear in the same cycle
    always_ff @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            pid_low_reg  <= adp_pkg::PID_RESET;
            pid_high_reg <= adp_pkg::PID_RESET;
        end
        else if (pid_load)
        begin
            pid_low_reg  <= l_udw[15:0];
            pid_high_reg <= l_udw[31:16];
        end
        else if (pid_clr)
        begin
            pid_low_reg  <= adp_pkg::PID_RESET;
            pid_high_reg <= adp_pkg::PID_RESET;
        end
    end

    // frame boundary counter for the missing-packet timeout
    always_ff @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
            tmo_cnt_reg <= 2'h0;
        else if (pid_load || tmo_hit)
            tmo_cnt_reg <= 2'h0;
        else if (I_FRAME_START)
            tmo_cnt_reg <= tmo_cnt_reg + 2'h1;
    end

    // flag and data output registers, aligned with the delayed stream
    always_ff @(posedge I_CORE_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            luma_flag_reg   <= 1'b0;
            chroma_flag_reg <= 1'b0;
            edh_reg         <= 1'b0;
            luma_out_reg    <= 10'h000;
            chroma_out_reg  <= 10'h000;
        end
        else
        begin
            luma_flag_reg   <= luma_nx;
            chroma_flag_reg <= chr_nx;
            edh_reg         <= edh_nx;
            luma_out_reg    <= l_data;
            chroma_out_reg  <= c_data;
        end
    end

    assign O_HOST_RDATA      = rdata_reg;
    assign O_LUMA_DATA       = luma_out_reg;
    assign O_CHROMA_DATA     = chroma_out_reg;
    assign O_LUMA_ANC_FLAG   = luma_flag_reg;
    assign O_CHROMA_ANC_FLAG = chroma_flag_reg;
    assign O_EDH_DETECT      = edh_reg;

    // checks of the block's own behaviour
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);

    flags_off_idle_a : assert property (!proc_on |=> !O_LUMA_ANC_FLAG && !O_CHROMA_ANC_FLAG)
        else $error("flag raised outside smpte processing");
    mux_flags_tied_a : assert property (sd_mux |=> O_LUMA_ANC_FLAG == O_CHROMA_ANC_FLAG)
        else $error("muxed sd flags differ");
    hd_chroma_own_a : assert property (!rate_q |=> O_CHROMA_ANC_FLAG == $past(c_flag))
        else $error("hd chroma flag not from chroma stream");
    flag_rise_adf_a : assert property ($rose(O_LUMA_ANC_FLAG) |-> O_LUMA_DATA == adp_pkg::ADF0)
        else $error("luma flag rose off preamble");
    nomatch_low_a : assert property (l_live && !l_match |=> !O_LUMA_ANC_FLAG)
        else $error("luma flag on unmatched packet");
    all_zero_pass_a : assert property (proc_on && l_live && slot_reg[0] == 16'h0000
        && slot_reg[1] == 16'h0000 && slot_reg[2] == 16'h0000 && slot_reg[3] == 16'h0000
        && slot_reg[4] == 16'h0000 |=> O_LUMA_ANC_FLAG)
        else $error("packet dropped with all slots zero");
    pid_unlock_clr_a : assert property (!lock_q && !pid_load |=> pid_low_reg == 16'h0000
        && pid_high_reg == 16'h0000)
        else $error("payload id kept while unlocked");
    pid_timeout_a : assert property (tmo_hit && !pid_load |=> pid_low_reg == 16'h0000)
        else $error("payload id kept after timeout");
    pid_only_good_a : assert property ($changed(pid_low_reg) |-> $past(pid_load || pid_clr))
        else $error("payload id changed without cause");
    pid_capture_a : assert property (pid_load |=> pid_high_reg == $past(l_udw[31:16]))
        else $error("payload id bytes misplaced");

    luma_pkt_c : cover property ($fell(O_LUMA_ANC_FLAG));
    pid_load_c : cover property (pid_load);
    pid_tmo_c  : cover property (tmo_hit && pid_low_reg != 16'h0000);
    edh_seen_c : cover property (O_EDH_DETECT);
endmodule : adp_anc_detect

// ==== adp_fifo_model.sv ====
// downstream store that writes each output word whose ancillary flag is high
// assumes data and flag come from the detector on the same pixel clock
`timescale 1ns/1ps
module adp_fifo_model
(
    // clock and clear
    input  wire logic       i_clk,
    input  wire logic       i_clr,
    // detector output
    input  wire logic [9:0] i_data,
    input  wire logic       i_flag,
    // observed store contents
    output int              o_count,
    output logic      [9:0] o_first
);
    // flag acts as a plain write enable on the pixel clock
    always @(posedge i_clk)
    begin
        if (i_clr)
        begin
            o_count <= 0;
            o_first <= 10'h155;
        end
        else if (i_flag === 1'b1)
        begin
            if (o_count == 0)
                o_first <= i_data;
            o_count <= o_count + 1;
        end
    end
endmodule : adp_fifo_model

// ==== adp_anc_detect_tb_top.sv ====
// self-checking bench for the ancillary detector and payload id extractor
// assumes the detector delays video by 7 cycles and registers host reads
`timescale 1ns/1ps
module adp_anc_detect_tb_top;
    typedef struct packed {logic [15:0] slot; logic [7:0] did; logic [7:0] sdid; logic flag;}
        adp_row_type;
    logic        clk;
    logic        rst;
    logic  [9:0] luma_d, chroma_d, luma_q, chroma_q;
    logic        frame_st, rate_sel, mux10, lock, proc_en, smpte, clr;
    logic  [7:0] addr;
    logic        wr, rd, luma_flg, chroma_flg, edh_flg;
    logic [15:0] wdata, rdata;
    int          luma_cnt, chroma_cnt, edh_cnt, error_cnt, cmp_count;
    logic  [9:0] luma_first, chroma_first;
    logic  [7:0] udw [4];
    // slot value, header, whether the luma flag should rise
    adp_row_type rows [7] = '{'{16'h0000, 8'h60, 8'h60, 1'b1}, '{16'h6060, 8'h60, 8'h60, 1'b1},
        '{16'h6060, 8'h60, 8'h61, 1'b0}, '{16'h6000, 8'h60, 8'h77, 1'b1},
        '{16'h0060, 8'h33, 8'h60, 1'b1}, '{16'h6000, 8'h61, 8'h00, 1'b0},
        '{16'h6060, 8'hf4, 8'h00, 1'b0}};

    always #20 clk = ~clk;

    adp_anc_detect i_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_LUMA_DATA(luma_d),
        .I_CHROMA_DATA(chroma_d), .I_FRAME_START(frame_st), .I_RATE_SELECT(rate_sel),
        .I_MUX_10BIT(mux10), .I_LOCK_INDICATOR(lock), .I_PROCESSING_ENABLE(proc_en),
        .I_SMPTE_MODE(smpte), .I_HOST_ADDR(addr), .I_HOST_WR(wr), .I_HOST_RD(rd),
        .I_HOST_WDATA(wdata), .O_HOST_RDATA(rdata), .O_LUMA_DATA(luma_q),
        .O_CHROMA_DATA(chroma_q), .O_LUMA_ANC_FLAG(luma_flg),
        .O_CHROMA_ANC_FLAG(chroma_flg), .O_EDH_DETECT(edh_flg));
    adp_fifo_model i_luma (.i_clk(clk), .i_clr(clr), .i_data(luma_q), .i_flag(luma_flg),
        .o_count(luma_cnt), .o_first(luma_first));
    adp_fifo_model i_chroma (.i_clk(clk), .i_clr(clr), .i_data(chroma_q),
        .i_flag(chroma_flg), .o_count(chroma_cnt), .o_first(chroma_first));
    adp_fifo_model i_edh (.i_clk(clk), .i_clr(clr), .i_data(luma_q), .i_flag(edh_flg),
        .o_count(edh_cnt), .o_first());

    // step to just after the next rising edge
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // host write, strobe one cycle then a gap
    task automatic host_wr(input logic [7:0] a, input logic [15:0] d);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        tick;
        wr    = 1'b0;
        tick;
    endtask : host_wr

    // host read, data visible after the strobe edge
    task automatic host_rd(input logic [7:0] a, input logic [15:0] exp);
        addr = a;
        rd   = 1'b1;
        tick;
        rd   = 1'b0;
        check(rdata, exp);
        tick;
    endtask : host_rd

    // one packet with four user words, then idle long enough to drain
    task automatic send_pkt(input logic ch, input logic [7:0] did, input logic [7:0] sdid,
                            input logic bad);
        logic [9:0] w [11];
        logic [8:0] s;
        w[0] = 10'h000;
        w[1] = 10'h3ff;
        w[2] = 10'h3ff;
        w[3] = {2'b10, did};
        w[4] = {2'b10, sdid};
        w[5] = {2'b10, 8'h04};
        for (int k = 0; k < 4; k++)
            w[6 + k] = {2'b01, udw[k]};
        s = 9'h000;
        for (int k = 3; k < 10; k++)
            s = s + w[k][8:0];
        w[10] = {~s[8], s} ^ {9'h000, bad};
        clr = 1'b1;
        tick;
        clr = 1'b0;
        for (int k = 0; k < 11; k++)
        begin
            if (ch)
                chroma_d = w[k];
            else
                luma_d = w[k];
            tick;
        end
        luma_d   = 10'h040;
        chroma_d = 10'h200;
        repeat (12) tick;
    endtask : send_pkt

    // frame boundary pulse, one per frame as the source would give
    task automatic frame_pulse;
        frame_st = 1'b1;
        tick;
        frame_st = 1'b0;
        tick;
    endtask : frame_pulse

    // counts, verdict and end of run
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // main sequence
    initial
    begin
        clk = 1'b0; rst = 1'b1; luma_d = 10'h040; chroma_d = 10'h200; frame_st = 1'b0;
        rate_sel = 1'b0; mux10 = 1'b0; lock = 1'b1; proc_en = 1'b1; smpte = 1'b1;
        clr = 1'b0; addr = 8'h00; wr = 1'b0; rd = 1'b0; wdata = 16'h0000;
        error_cnt = 0; cmp_count = 0; udw = '{8'h12, 8'h34, 8'h56, 8'h78};
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) tick;
        for (int a = 5; a < 10; a++)
            host_rd(a[7:0], 16'h0000);
        host_rd(8'h0c, 16'h0000);
        host_rd(8'h0d, 16'h0000);
        host_wr(8'h09, 16'hbeef);
        host_rd(8'h09, 16'hbeef);
        host_wr(8'h0c, 16'h1234);
        host_rd(8'h0c, 16'h0000);
        host_rd(8'h0e, 16'h0000);
        host_wr(8'h09, 16'h0000);
        $display("register test done");
        foreach (rows[i])
        begin
            host_wr(8'h05, rows[i].slot);
            send_pkt(1'b0, rows[i].did, rows[i].sdid, 1'b0);
            check(luma_cnt, rows[i].flag ? 11 : 0);
            check(chroma_cnt, 0);
            check(edh_cnt, (rows[i].did == 8'hf4) ? 11 : 0);
            if (rows[i].flag)
                check(luma_first, 10'h000);
        end
        host_wr(8'h05, 16'h0000);
        $display("match table test done");
        send_pkt(1'b1, 8'h60, 8'h60, 1'b0);
        check(luma_cnt, 0);
        check(chroma_cnt, 11);
        check(chroma_first, 10'h000);
        rate_sel = 1'b1;
        repeat (4) tick;
        send_pkt(1'b1, 8'h60, 8'h60, 1'b0);
        check(luma_cnt, 0);
        check(chroma_cnt, 11);
        mux10 = 1'b1;
        repeat (4) tick;
        send_pkt(1'b0, 8'h60, 8'h60, 1'b0);
        check(luma_cnt, 11);
        check(chroma_cnt, 11);
        rate_sel = 1'b0;
        mux10 = 1'b0;
        repeat (4) tick;
        $display("stream mode test done");
        send_pkt(1'b0, 8'h41, 8'h01, 1'b0);
        host_rd(8'h0c, 16'h3412);
        host_rd(8'h0d, 16'h7856);
        udw = '{8'haa, 8'hbb, 8'hcc, 8'hdd};
        send_pkt(1'b0, 8'h41, 8'h01, 1'b1);
        host_rd(8'h0c, 16'h3412);
        frame_pulse;
        frame_pulse;
        host_rd(8'h0c, 16'h3412);
        frame_pulse;
        host_rd(8'h0c, 16'h0000);
        send_pkt(1'b0, 8'h41, 8'h01, 1'b0);
        host_rd(8'h0d, 16'hddcc);
        lock = 1'b0;
        repeat (4) tick;
        lock = 1'b1;
        host_rd(8'h0d, 16'h0000);
        send_pkt(1'b0, 8'h41, 8'h01, 1'b0);
        proc_en = 1'b0;
        repeat (4) tick;
        proc_en = 1'b1;
        host_rd(8'h0c, 16'h0000);
        send_pkt(1'b0, 8'h41, 8'h01, 1'b0);
        smpte = 1'b0;
        repeat (4) tick;
        udw = '{8'h11, 8'h22, 8'h33, 8'h44};
        send_pkt(1'b0, 8'h41, 8'h01, 1'b0);
        check(luma_cnt, 0);
        host_rd(8'h0c, 16'hbbaa);
        $display("payload id test done");
        // mid-run reset must clear slots and payload id again
        host_wr(8'h05, 16'h6060);
        rst = 1'b1;
        repeat (2) tick;
        rst = 1'b0;
        repeat (3) tick;
        host_rd(8'h05, 16'h0000);
        host_rd(8'h0c, 16'h0000);
        $display("reset test done");
        test_done;
    end

    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done;
    end
endmodule : adp_anc_detect_tb_top
